// *** rtl/ssr_pkg.sv ***
// status reporting package: register map, field positions, reset values, carriers
// assumes a 32-bit classic wishbone bus with byte addresses
package ssr_pkg;

   localparam int NUM_GROUPS = 4;
   localparam int GRP_W = 16;

   // group index, address bits [6:5]
   localparam logic [1:0] GRP_OPER = 2'h0;
   localparam logic [1:0] GRP_QUES = 2'h1;
   localparam logic [1:0] GRP_DEV = 2'h2;
   localparam logic [1:0] GRP_STD = 2'h3;

   // word offsets inside a group window
   localparam logic [4:0] FLD_COND = 5'h00;
   localparam logic [4:0] FLD_PTR = 5'h04;
   localparam logic [4:0] FLD_NTR = 5'h08;
   localparam logic [4:0] FLD_EVT = 5'h0c;
   localparam logic [4:0] FLD_ENA = 5'h10;

   // summary block
   localparam logic [7:0] OFS_STB = 8'h80;
   localparam logic [7:0] OFS_SRE = 8'h84;
   localparam logic [7:0] OFS_CTRL = 8'h88;

   // control word bits (write only)
   localparam int CTRL_CLS = 0;
   localparam int CTRL_PRESET = 1;

   // status byte bit positions
   localparam int STB_DEV = 1;
   localparam int STB_ERRQ = 2;
   localparam int STB_QUES = 3;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_RQS = 6;
   localparam int STB_OPER = 7;

   // valid bits: 16-bit groups drop bit 15, byte groups keep the low byte
   localparam logic [15:0] MASK16 = 16'h7fff;
   localparam logic [15:0] MASK8 = 16'h00ff;
   localparam logic [15:0] GRP_VALID [NUM_GROUPS] = '{MASK16, MASK16, MASK16, MASK8};

   localparam logic [15:0] PTR_PRESET = 16'hffff;
   localparam logic [15:0] NTR_PRESET = 16'h0000;
   localparam logic [15:0] ENA_RESET = 16'h0000;
   localparam logic [7:0] SRE_RESET = 8'h00;
   // rqs is never an enable source
   localparam logic [7:0] SRE_MASK = 8'hbf;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ssr_wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } ssr_wb_rsp_type;

   typedef struct packed {
      logic [15:0] cond;
      logic [15:0] prev;
      logic [15:0] ptr;
      logic [15:0] ntr;
      logic [15:0] evt;
      logic [15:0] ena;
   } ssr_grp_state_type;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [7:0] sre;
      logic srq;
      logic mav;
      logic errq;
   } ssr_top_state_type;

endpackage

// *** rtl/ssr_status_group.sv ***
// one status group: condition, transition filters, latched event, enable, summary
// assumes condition inputs are synchronous to mclk
`timescale 1ns/1ps
module ssr_status_group #(
   parameter logic [15:0] VALID = ssr_pkg::MASK16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // live condition
   input wire logic [15:0] cond_in,
   // host side controls
   input wire logic [15:0] wr_data,
   input wire logic [1:0] ptr_we,
   input wire logic [1:0] ntr_we,
   input wire logic [1:0] ena_we,
   input wire logic evt_clr,
   input wire logic preset,
   // register images
   output ssr_pkg::ssr_grp_state_type view,
   output logic summary
);

   localparam ssr_pkg::ssr_grp_state_type RST_STATE = '{
      cond: 16'h0000, prev: 16'h0000, ptr: ssr_pkg::PTR_PRESET & VALID,
      ntr: ssr_pkg::NTR_PRESET, evt: 16'h0000, ena: ssr_pkg::ENA_RESET};

   ssr_pkg::ssr_grp_state_type s_reg, s_next;
   logic [15:0] qual_set;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // masked rise or fall, as chosen by the filters
   assign qual_set = ((s_reg.cond & ~s_reg.prev & s_reg.ptr) | (~s_reg.cond & s_reg.prev & s_reg.ntr)) & VALID;

   always_comb begin
      s_next = s_reg;
      s_next.cond = cond_in & VALID;
      s_next.prev = s_reg.cond;
      // filters keep their value across clears and reads
      s_next.ptr = merge(s_reg.ptr, wr_data, ptr_we) & VALID;
      s_next.ntr = merge(s_reg.ntr, wr_data, ntr_we) & VALID;
      if (preset) begin
         s_next.ptr = ssr_pkg::PTR_PRESET & VALID;
         s_next.ntr = ssr_pkg::NTR_PRESET;
      end
      s_next.ena = merge(s_reg.ena, wr_data, ena_we) & VALID;
      // a new event beats a clear in the same cycle
      s_next.evt = ((evt_clr ? 16'h0000 : s_reg.evt) | qual_set) & VALID;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s_reg <= RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign view = s_reg;
   assign summary = |(s_reg.evt & s_reg.ena);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_evt_capture_win: assert property ((qual_set != 16'h0000) |=> ((s_reg.evt & $past(qual_set)) == $past(qual_set)))
      else $error("qualified transition lost");
   a_evt_stays_set: assert property (!evt_clr |=> ((s_reg.evt & $past(s_reg.evt)) == $past(s_reg.evt)))
      else $error("event bit dropped without clear");
   a_evt_only_filtered: assert property (1'b1 |=> ((s_reg.evt & ~$past(s_reg.evt) & ~$past(qual_set)) == 16'h0000))
      else $error("event set without qualified transition");
   a_unused_msb_zero: assert property (((s_reg.cond | s_reg.ptr | s_reg.ntr | s_reg.evt | s_reg.ena) & ~VALID) == 16'h0000)
      else $error("unused bit set");
   a_preset_filters: assert property (preset |=> (s_reg.ptr == (ssr_pkg::PTR_PRESET & VALID)) && (s_reg.ntr == 16'h0000))
      else $error("preset did not load filters");
   c_event_latched: cover property (qual_set != 16'h0000 ##1 evt_clr);

endmodule

// *** rtl/ssr_status_report.sv ***
// status reporting top: four status groups, status byte, service request line,
// classic wishbone register slave
// assumes condition, queue and bus inputs are synchronous to mclk
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// Summary of operation
// - condition registers track live state every cycle and are read only
// - event bit sets on a rise or fall only when that filter bit allows
// - both filters are host read/write; clears and reads never change them
// - preset loads negative filter with zeros, positive filter with ones
// - a set event bit holds until the event register is cleared
// - event register is read only, cleared by its read or clear-status
// - group summary is the or of event anded with enable
// - enable registers are read/write; reading leaves them unchanged
// - every group holds condition, both filters, event and enable
// - service request asserts while any enabled status byte bit is set
// - status byte bit 4 (weight 16) shows queued output data
// - reading the request enable mask returns the weighted enabled bits
// - with no request enabled the block never signals, only answers reads
// - status byte and standard event apart from operation and questionable
// - operation and questionable are 16 bits; byte groups are 8 bits
// - top bit of every 16-bit group is unused and reads zero
// - message available clears once all queued output has been read
module ssr_status_report (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // wishbone slave
   input ssr_pkg::ssr_wb_req_type wb_req,
   output ssr_pkg::ssr_wb_rsp_type wb_rsp,
   // live conditions
   input wire logic [15:0] oper_cond,
   input wire logic [15:0] ques_cond,
   input wire logic [15:0] dev_cond,
   input wire logic [7:0] std_cond,
   // queue levels
   input wire logic err_queue_nonempty,
   input wire logic out_queue_nonempty,
   // service request line toward the controller
   output logic srq
);

   localparam ssr_pkg::ssr_top_state_type RST_STATE = '{
      ack: 1'b0, rdat: 32'h0000_0000, sre: ssr_pkg::SRE_RESET,
      srq: 1'b0, mav: 1'b0, errq: 1'b0};

   ssr_pkg::ssr_top_state_type s_reg, s_next;

   // per group wiring
   logic [15:0] cond_all [ssr_pkg::NUM_GROUPS];
   ssr_pkg::ssr_grp_state_type view [ssr_pkg::NUM_GROUPS];
   logic [ssr_pkg::NUM_GROUPS-1:0] sum;
   logic [1:0] ptr_we [ssr_pkg::NUM_GROUPS];
   logic [1:0] ntr_we [ssr_pkg::NUM_GROUPS];
   logic [1:0] ena_we [ssr_pkg::NUM_GROUPS];
   logic [ssr_pkg::NUM_GROUPS-1:0] evt_clr;

   // decode
   logic hit;
   logic wr;
   logic rd;
   logic in_grp;
   logic [1:0] grp;
   logic [4:0] fld;
   logic cls;
   logic preset;
   logic [7:0] stb_img;
   logic req_any;
   logic [31:0] rd_mux;

   assign cond_all[ssr_pkg::GRP_OPER] = oper_cond;
   assign cond_all[ssr_pkg::GRP_QUES] = ques_cond;
   assign cond_all[ssr_pkg::GRP_DEV] = dev_cond;
   assign cond_all[ssr_pkg::GRP_STD] = {8'h00, std_cond};

   // one access per request; ack is never repeated back to back
   assign hit = wb_req.cyc & wb_req.stb & ~s_reg.ack;
   assign wr = hit & wb_req.we;
   assign rd = hit & ~wb_req.we;
   assign in_grp = ~wb_req.adr[7];
   assign grp = wb_req.adr[6:5];
   assign fld = wb_req.adr[4:0];

   assign cls = wr & (wb_req.adr == ssr_pkg::OFS_CTRL) & wb_req.sel[0]
                & wb_req.dat[ssr_pkg::CTRL_CLS];
   assign preset = wr & (wb_req.adr == ssr_pkg::OFS_CTRL) & wb_req.sel[0]
                   & wb_req.dat[ssr_pkg::CTRL_PRESET];

   // all four groups sit in group windows, status byte and request enable in the
   // summary window
   always_comb begin
      for (int g = 0; g < ssr_pkg::NUM_GROUPS; g++) begin
         ptr_we[g] = 2'h0;
         ntr_we[g] = 2'h0;
         ena_we[g] = 2'h0;
         if (wr && in_grp && (grp == 2'(g))) begin
            if (fld == ssr_pkg::FLD_PTR) begin
               ptr_we[g] = wb_req.sel[1:0];
            end
            if (fld == ssr_pkg::FLD_NTR) begin
               ntr_we[g] = wb_req.sel[1:0];
            end
            if (fld == ssr_pkg::FLD_ENA) begin
               ena_we[g] = wb_req.sel[1:0];
            end
         end
         // reading the event word empties it; clear-status empties all
         evt_clr[g] = cls | (rd & in_grp & (grp == 2'(g)) & (fld == ssr_pkg::FLD_EVT));
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < ssr_pkg::NUM_GROUPS; gi++) begin : g_grp
         ssr_status_group #(
            .VALID(ssr_pkg::GRP_VALID[gi])
         ) u_grp (
            .mclk(mclk),
            .rst_b(rst_b),
            .cond_in(cond_all[gi]),
            .wr_data(wb_req.dat[15:0]),
            .ptr_we(ptr_we[gi]),
            .ntr_we(ntr_we[gi]),
            .ena_we(ena_we[gi]),
            .evt_clr(evt_clr[gi]),
            .preset(preset),
            .view(view[gi]),
            .summary(sum[gi])
         );
      end
   endgenerate

   // status byte; bit 0 is unused and reads zero
   always_comb begin
      stb_img = 8'h00;
      stb_img[ssr_pkg::STB_DEV] = sum[ssr_pkg::GRP_DEV];
      stb_img[ssr_pkg::STB_ERRQ] = s_reg.errq;
      stb_img[ssr_pkg::STB_QUES] = sum[ssr_pkg::GRP_QUES];
      stb_img[ssr_pkg::STB_MAV] = s_reg.mav;
      stb_img[ssr_pkg::STB_ESB] = sum[ssr_pkg::GRP_STD];
      stb_img[ssr_pkg::STB_RQS] = s_reg.srq;
      stb_img[ssr_pkg::STB_OPER] = sum[ssr_pkg::GRP_OPER];
   end

   // rqs is excluded so the line cannot hold itself up
   assign req_any = |(stb_img & s_reg.sre & ssr_pkg::SRE_MASK);

   // read mux; reads have no side effect except on the event word
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (in_grp) begin
         case (fld)
            ssr_pkg::FLD_COND: rd_mux = {16'h0000, view[grp].cond};
            ssr_pkg::FLD_PTR: rd_mux = {16'h0000, view[grp].ptr};
            ssr_pkg::FLD_NTR: rd_mux = {16'h0000, view[grp].ntr};
            ssr_pkg::FLD_EVT: rd_mux = {16'h0000, view[grp].evt};
            ssr_pkg::FLD_ENA: rd_mux = {16'h0000, view[grp].ena};
            default: rd_mux = 32'h0000_0000;
         endcase
      end else begin
         case (wb_req.adr)
            ssr_pkg::OFS_STB: rd_mux = {24'h00_0000, stb_img};
            ssr_pkg::OFS_SRE: rd_mux = {24'h00_0000, s_reg.sre};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.ack = hit;
      s_next.rdat = rd ? rd_mux : 32'h0000_0000;
      if (wr && (wb_req.adr == ssr_pkg::OFS_SRE) && wb_req.sel[0]) begin
         s_next.sre = wb_req.dat[7:0] & ssr_pkg::SRE_MASK;
      end
      // queue levels follow their sources; no latching here
      s_next.mav = out_queue_nonempty;
      s_next.errq = err_queue_nonempty;
      s_next.srq = req_any;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s_reg <= RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_rsp = '{ack: s_reg.ack, dat: s_reg.rdat};
   assign srq = s_reg.srq;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_srq_tracks_mask: assert property (1'b1 |=> (srq == $past(req_any)))
      else $error("srq does not follow enabled status bits");
   a_srq_silent_off: assert property ((s_reg.sre == 8'h00) [*2] |-> !srq)
      else $error("srq asserted with no enable");
   a_mav_follows_q: assert property (out_queue_nonempty ##1 out_queue_nonempty |-> stb_img[ssr_pkg::STB_MAV])
      else $error("message available not shown");
   a_mav_clears: assert property (!out_queue_nonempty ##1 !out_queue_nonempty |-> !stb_img[ssr_pkg::STB_MAV])
      else $error("message available stuck");
   a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack held for two cycles");
   // a transition in the reading cycle may set a bit again, so only older bits must go
   a_evt_read_clear: assert property (rd && in_grp && (fld == ssr_pkg::FLD_EVT) && (grp == ssr_pkg::GRP_OPER)
      |=> ((view[0].evt & $past(view[0].evt) & ~$past(g_grp[0].u_grp.qual_set)) == 16'h0000))
      else $error("event read did not clear");
   a_filters_survive: assert property (cls && !preset |=> (view[1].ptr == $past(view[1].ptr))
                                       && (view[1].ntr == $past(view[1].ntr)))
      else $error("clear-status changed a filter");
   a_sum_matches: assert property (stb_img[ssr_pkg::STB_ESB] ==
      |(view[ssr_pkg::GRP_STD].evt & view[ssr_pkg::GRP_STD].ena))
      else $error("summary mismatch");
   a_ack_answers: assert property (hit |=> wb_rsp.ack)
      else $error("request not acknowledged");
   a_rdat_idle: assert property (!wb_rsp.ack |-> (wb_rsp.dat == 32'h0000_0000))
      else $error("read data not zero outside ack");
   a_sre_rqs_zero: assert property (s_reg.sre[ssr_pkg::STB_RQS] == 1'b0)
      else $error("request enable holds the rqs bit");
   a_sre_write: assert property (wr && (wb_req.adr == ssr_pkg::OFS_SRE) && wb_req.sel[0]
      |=> (s_reg.sre == ($past(wb_req.dat[7:0]) & ssr_pkg::SRE_MASK)))
      else $error("request enable write lost");
   a_cond_live: assert property (1'b1 |=>
      (view[ssr_pkg::GRP_QUES].cond == ($past(ques_cond) & ssr_pkg::MASK16)))
      else $error("condition does not follow its input");
   a_std_cond_byte: assert property (1'b1 |=> (view[ssr_pkg::GRP_STD].cond == {8'h00, $past(std_cond)}))
      else $error("standard condition wider than a byte");
   a_ena_read_keeps: assert property (rd && in_grp && (fld == ssr_pkg::FLD_ENA)
      && (grp == ssr_pkg::GRP_OPER) |=> (view[ssr_pkg::GRP_OPER].ena == $past(view[ssr_pkg::GRP_OPER].ena)))
      else $error("enable read changed the enable word");
   a_stb_read_pure: assert property (rd && (wb_req.adr == ssr_pkg::OFS_STB)
      |=> ((view[ssr_pkg::GRP_DEV].evt & $past(view[ssr_pkg::GRP_DEV].evt)) == $past(view[ssr_pkg::GRP_DEV].evt)))
      else $error("status byte read cleared an event");
   // new transitions in the clearing cycle survive, everything older must go
   a_cls_clears_all: assert property (cls |=>
      ((view[ssr_pkg::GRP_DEV].evt & $past(view[ssr_pkg::GRP_DEV].evt)
      & ~$past(g_grp[ssr_pkg::GRP_DEV].u_grp.qual_set)) == 16'h0000))
      else $error("clear-status left an event");

   c_srq_raised: cover property (!srq ##1 srq);
   c_stb_read: cover property (rd && (wb_req.adr == ssr_pkg::OFS_STB) && srq);
   c_preset_seen: cover property (preset);
   c_cls_with_event: cover property (cls && (sum != 4'h0));

endmodule

// *** verif/ssr_host_model.sv ***
// controller-side model: classic wishbone master tasks and the service request input
// assumes the block answers every request with a one-cycle ack
`timescale 1ns/1ps
module ssr_host_model (
   // clock
   input wire logic mclk,
   // bus toward the block
   output ssr_pkg::ssr_wb_req_type wb_req,
   input ssr_pkg::ssr_wb_rsp_type wb_rsp,
   // service request line and model status
   input wire logic srq,
   output logic hung,
   output logic irq_seen
);
   logic irq_en;
   // byte lanes of the next request; full word unless a test narrows it
   logic [3:0] lanes;

   initial begin
      wb_req = '0;
      lanes = 4'hf;
      hung = 1'b0;
      irq_seen = 1'b0;
      irq_en = 1'b0;
   end

   // interrupts are only taken once the controller has armed itself
   always @(posedge mclk) begin
      if (irq_en && srq === 1'b1) irq_seen <= 1'b1;
   end

   // request held unchanged until ack is sampled at a rising edge
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int i;
      @(posedge mclk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: lanes, dat: wd};
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (wb_rsp.ack === 1'b1) break;
      end
      if (i == 20) hung <= 1'b1;
      rd = wb_rsp.dat;
      wb_req <= '0;
   endtask

   // bring-up order; the bus device clear has no pin on this block
   task automatic arm(input logic [7:0] sre_mask);
      logic [31:0] d;
      xfer(1'b1, 8'h88, 32'h1, d);
      xfer(1'b1, 8'h70, 32'hff, d);
      xfer(1'b1, 8'h84, {24'h0, sre_mask}, d);
      irq_en = 1'b1;
   endtask
endmodule

// *** verif/tb_status_group_srq_reporting.sv ***
// self-checking bench for the status reporting top
// assumes the controller model issues every bus request
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_status_group_srq_reporting;
   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] wd;
      logic [31:0] exp;
   } ssr_row_type;

   logic mclk;
   logic rst_b;
   ssr_pkg::ssr_wb_req_type wb_req;
   ssr_pkg::ssr_wb_rsp_type wb_rsp;
   logic [15:0] oper_cond;
   logic [15:0] ques_cond;
   logic [15:0] dev_cond;
   logic [7:0] std_cond;
   logic err_queue_nonempty;
   logic out_queue_nonempty;
   logic srq;
   logic hung;
   logic irq_seen;
   logic [31:0] rd;
   int n_fail;
   int compares;
   // write, two reads, expected data; bit 15 and upper byte lanes must drop
   ssr_row_type rows [12] = '{
      '{8'h04, 32'hffff, 32'h7fff}, '{8'h08, 32'h1ffff, 32'h7fff}, '{8'h10, 32'h1234, 32'h1234},
      '{8'h24, 32'h8001, 32'h0001}, '{8'h48, 32'h0f0f, 32'h0f0f}, '{8'h64, 32'hffff, 32'h00ff},
      '{8'h70, 32'h01ff, 32'h00ff}, '{8'h00, 32'hffff, 32'h0005}, '{8'h20, 32'h0, 32'h0a0a},
      '{8'h60, 32'h0, 32'h0081}, '{8'h84, 32'hffff, 32'h00bf}, '{8'hfc, 32'hffff, 32'h0}};

   ssr_status_report u_dut (
      .mclk(mclk),
      .rst_b(rst_b),
      .wb_req(wb_req),
      .wb_rsp(wb_rsp),
      .oper_cond(oper_cond),
      .ques_cond(ques_cond),
      .dev_cond(dev_cond),
      .std_cond(std_cond),
      .err_queue_nonempty(err_queue_nonempty),
      .out_queue_nonempty(out_queue_nonempty),
      .srq(srq)
   );

   ssr_host_model u_host (
      .mclk(mclk),
      .wb_req(wb_req),
      .wb_rsp(wb_rsp),
      .srq(srq),
      .hung(hung),
      .irq_seen(irq_seen)
   );

   always #5 mclk = ~mclk;

   task wrap_up;
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge hung) begin
      n_fail++;
      wrap_up();
   end

   task do_reset;
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, rd);
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      u_host.xfer(1'b0, a, 32'h0, rd);
      `CHK(rd, e)
   endtask

   // four edges cover the condition, event and request register stages
   task cond_set(input logic [15:0] v);
      @(posedge mclk);
      oper_cond <= v;
      repeat (4) @(posedge mclk);
   endtask

   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      oper_cond = 16'h8005;
      ques_cond = 16'h0a0a;
      dev_cond = 16'h1111;
      std_cond = 8'h81;
      err_queue_nonempty = 1'b0;
      out_queue_nonempty = 1'b0;
      n_fail = 0;
      compares = 0;
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].adr, rows[i].wd);
         u_host.xfer(1'b0, rows[i].adr, 32'h0, rd);
         rd_chk(rows[i].adr, rows[i].exp);
      end
      // quiet conditions so the second release sees no edges
      oper_cond <= '0;
      ques_cond <= '0;
      dev_cond <= '0;
      std_cond <= '0;
      do_reset();
      `CHK(srq, 1'b0)
      rd_chk(8'h04, 32'h7fff);
      rd_chk(8'h64, 32'h00ff);
      rd_chk(8'h48, 32'h0);
      rd_chk(8'h6c, 32'h0);
      rd_chk(8'h84, 32'h0);
      wr(8'h04, 32'h0001);
      wr(8'h08, 32'h0002);
      cond_set(16'h0003);
      rd_chk(8'h0c, 32'h0001);
      cond_set(16'h0000);
      rd_chk(8'h0c, 32'h0002);
      cond_set(16'h0001);
      cond_set(16'h0000);
      rd_chk(8'h0c, 32'h0001);
      rd_chk(8'h0c, 32'h0);
      wr(8'h04, 32'h7fff);
      wr(8'h10, 32'h0001);
      u_host.arm(8'h80);
      cond_set(16'h0001);
      `CHK(srq, 1'b1)
      // the model latches srq one edge after it rises, so look after the read
      rd_chk(8'h80, 32'h00c0);
      `CHK(irq_seen, 1'b1)
      // transition lands on the same edge as the clear-status write
      @(posedge mclk);
      oper_cond <= 16'h0003;
      wr(8'h88, 32'h1);
      repeat (2) @(posedge mclk);
      `CHK(srq, 1'b0)
      rd_chk(8'h0c, 32'h0002);
      rd_chk(8'h08, 32'h0002);
      wr(8'h84, 32'h0);
      wr(8'h10, 32'h7fff);
      err_queue_nonempty <= 1'b1;
      out_queue_nonempty <= 1'b1;
      cond_set(16'h0007);
      `CHK(srq, 1'b0)
      rd_chk(8'h80, 32'h0094);
      wr(8'h84, 32'h10);
      repeat (3) @(posedge mclk);
      `CHK(srq, 1'b1)
      out_queue_nonempty <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK(srq, 1'b0)
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h1234);
      wr(8'h88, 32'h2);
      rd_chk(8'h04, 32'h7fff);
      rd_chk(8'h08, 32'h0);
      // low byte lane only: the upper byte of the filter keeps its preset zeros
      u_host.lanes <= 4'h1;
      wr(8'h28, 32'hffff);
      u_host.lanes <= 4'hf;
      rd_chk(8'h28, 32'h00ff);
      wrap_up();
   end
endmodule
